// >>> src/adcrd_pkg.sv
package adcrd_pkg;

    // nominal converter clock and the rates that follow from it
    localparam int SYS_CLK_HZ    = 2457600;
    localparam int MOD_RATE_HZ   = 19200;
    localparam int DATA_RATE_SPS = 15;
    localparam int MOD_DIV       = SYS_CLK_HZ / MOD_RATE_HZ;
    localparam int CONV_SAMPLES  = MOD_RATE_HZ / DATA_RATE_SPS;
    localparam int CONV_CLKS     = MOD_DIV * CONV_SAMPLES;

    // widths
    localparam int RES_W   = 24;
    localparam int SAMP_W  = 26;
    localparam int ACC_W   = 36;
    localparam int DIV_W   = 7;
    localparam int CNT_W   = 11;
    localparam int BIT_W   = 5;
    localparam int GAP_W   = 18;
    localparam int RECIP_W = 16;
    localparam int FIFO_DEPTH = 32;

    // divider, sample counter and bit counter end values
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MOD_DIV - 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_SAMPLES - 1);
    localparam logic [CNT_W-1:0] CNT_UPD  = CNT_W'(CONV_SAMPLES - 2);
    localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(RES_W);

    // full-scale codes, two's complement
    localparam logic [RES_W-1:0] FS_POS = 24'h7F_FFFF;
    localparam logic [RES_W-1:0] FS_NEG = 24'h80_0000;

    // 1/CONV_SAMPLES as RECIP / 2**SCALE_SHIFT
    localparam logic [RECIP_W-1:0] RECIP = 16'h3333;
    localparam int SCALE_SHIFT = 24;

    // pin level while no result is pending
    localparam logic PIN_IDLE = 1'b1;

    typedef enum logic [1:0] {
        RD_IDLE,
        RD_READY,
        RD_SHIFT,
        RD_UPDATE
    } adcrd_rd_e;

endpackage

// >>> src/adcrd_fifo.sv
`timescale 1ns/1ps
module adcrd_fifo
    import adcrd_pkg::*;
#(
    parameter int W     = SAMP_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic         ref_clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr_ptr;
        logic [AW-1:0]           rd_ptr;
        logic [AW:0]             count;
    } adcrd_fifo_s;

    adcrd_fifo_s st;
    adcrd_fifo_s next_st;
    logic        push;
    logic        pop;

    // honest full and empty from the fill count
    assign in_ready_o  = (st.count != (AW+1)'(DEPTH));
    assign out_valid_o = (st.count != '0);
    assign out_data_o  = st.mem[st.rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // pointer and storage update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data_i;
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_st.count = st.count + 1'b1;
        end else if (pop && !push) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule

// >>> src/adcrd_readout.sv
`timescale 1ns/1ps
// Operation
// - pin goes low when a new result is ready.
// - first shift-clock rise after ready puts the result MSB on the pin.
// - each further rise moves to next lower bit; falling edges do nothing.
// - extra rise after 24 bits forces pin high until next result.
// - nominal clock gives 15 results per second, notches at 50/60 Hz.
// - data rate and filter response scale with the system clock.
// - response repeats at 19.2 kHz, low-pass with 13.7 Hz cutoff.
// - pin falling edge marks the start of the next conversion.
// - input change aligned to conversion start settles in one result.
// - output clips at full scale when input exceeds twice reference.
// - result is 24-bit two's complement, full scale at extreme codes.
module adcrd_readout
    import adcrd_pkg::*;
#(
    parameter int TICK_DIV = MOD_DIV
) (
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    input  wire logic [SAMP_W-1:0] samp_data_i,
    input  wire logic              samp_valid_i,
    output logic                   samp_ready_o,
    input  wire logic              shift_clk_i,
    output logic                   ready_serial_out_pin_o,
    output logic [RES_W-1:0]       result_o,
    output logic                   conv_done_o
);

    typedef struct packed {
        logic              sclk_meta;
        logic              sclk_sync;
        logic              sclk_prev;
        logic [DIV_W-1:0]  div_cnt;
        logic              tick_pend;
        logic [CNT_W-1:0]  samp_cnt;
        logic [ACC_W-1:0]  acc;
        logic [RES_W-1:0]  result;
        logic [RES_W-1:0]  shreg;
        logic [BIT_W-1:0]  bit_cnt;
        adcrd_rd_e         rd_state;
        logic              pin;
        logic              done;
        logic [GAP_W-1:0]  gap_cnt;
        logic              gap_seen;
    } adcrd_state_s;

    adcrd_state_s      st;
    adcrd_state_s      next_st;
    logic [SAMP_W-1:0] fifo_data;
    logic              fifo_valid;
    logic              pop;
    logic              last_pop;
    logic              upd_pop;
    logic              sclk_rise;
    logic              sclk_fall;
    logic [RES_W-1:0]  samp_clip;
    logic [ACC_W-1:0]  samp_ext;
    logic [ACC_W-1:0]  sum;
    logic [RES_W-1:0]  conv_word;

    // modulator tick spacing; the default gives the nominal data rate
    localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_DIV - 1);

    // saturate a wide signed value to the 24-bit output range
    function automatic logic [RES_W-1:0] sat_res(input logic [ACC_W-1:0] v);
        logic signed [ACC_W-1:0] sv;
        sv = $signed(v);
        if (sv > $signed({{(ACC_W-RES_W){1'b0}}, FS_POS})) begin
            sat_res = FS_POS;
        end else if (sv < $signed({{(ACC_W-RES_W){1'b1}}, FS_NEG})) begin
            sat_res = FS_NEG;
        end else begin
            sat_res = v[RES_W-1:0];
        end
    endfunction

    // boxcar mean over one conversion, multiply by reciprocal then shift
    function automatic logic [RES_W-1:0] mean_res(input logic [ACC_W-1:0] a);
        logic signed [ACC_W+RECIP_W:0] p;
        logic signed [ACC_W+RECIP_W:0] q;
        p = $signed(a) * $signed({1'b0, RECIP});
        q = p >>> SCALE_SHIFT;
        mean_res = sat_res(q[ACC_W-1:0]);
    endfunction

    // modulator words are buffered; drained one per modulator tick
    adcrd_fifo #(
        .W     (SAMP_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .reset_i     (reset_i),
        .in_data_i   (samp_data_i),
        .in_valid_i  (samp_valid_i),
        .in_ready_o  (samp_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (st.tick_pend)
    );

    // edge detection reads only the second and third stages
    assign sclk_rise = st.sclk_sync && !st.sclk_prev;
    assign sclk_fall = !st.sclk_sync && st.sclk_prev;

    // input clipping and accumulation
    assign samp_clip = sat_res({{(ACC_W-SAMP_W){fifo_data[SAMP_W-1]}},
                                fifo_data});
    assign samp_ext  = {{(ACC_W-RES_W){samp_clip[RES_W-1]}}, samp_clip};
    assign sum       = st.acc + samp_ext;
    assign conv_word = mean_res(sum);
    assign pop       = st.tick_pend && fifo_valid;
    assign last_pop  = pop && (st.samp_cnt == CNT_LAST);
    assign upd_pop   = pop && (st.samp_cnt == CNT_UPD);

    // next-state logic
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        // two-stage synchroniser plus edge history
        next_st.sclk_meta = shift_clk_i;
        next_st.sclk_sync = st.sclk_meta;
        next_st.sclk_prev = st.sclk_sync;
        // modulator tick divider, runs off the system clock
        if (pop) begin
            next_st.tick_pend = 1'b0;
        end
        if (st.div_cnt == TICK_LAST) begin
            next_st.div_cnt = '0;
            next_st.tick_pend = 1'b1;
        end else begin
            next_st.div_cnt = st.div_cnt + 1'b1;
        end
        // serial readout on synchronised shift-clock rises
        if (sclk_rise) begin
            case (st.rd_state)
                RD_READY: begin
                    next_st.pin = st.shreg[RES_W-1];
                    next_st.shreg = {st.shreg[RES_W-2:0], 1'b0};
                    next_st.bit_cnt = BIT_W'(1);
                    next_st.rd_state = RD_SHIFT;
                end
                RD_SHIFT: begin
                    if (st.bit_cnt == BIT_LAST) begin
                        next_st.pin = PIN_IDLE;
                        next_st.rd_state = RD_IDLE;
                    end else begin
                        next_st.pin = st.shreg[RES_W-1];
                        next_st.shreg = {st.shreg[RES_W-2:0], 1'b0};
                        next_st.bit_cnt = st.bit_cnt + 1'b1;
                    end
                end
                default: begin
                    next_st.rd_state = st.rd_state;
                end
            endcase
        end
        // filter accumulation; conversion boundaries override readout
        if (last_pop) begin
            next_st.acc = '0;
            next_st.samp_cnt = '0;
            next_st.result = conv_word;
            next_st.shreg = conv_word;
            next_st.bit_cnt = '0;
            next_st.pin = 1'b0;
            next_st.rd_state = RD_READY;
            next_st.done = 1'b1;
        end else if (pop) begin
            next_st.acc = sum;
            next_st.samp_cnt = st.samp_cnt + 1'b1;
            if (upd_pop) begin
                next_st.pin = PIN_IDLE;
                next_st.rd_state = RD_UPDATE;
            end
        end
        // gap counter between results, checked below
        if (last_pop) begin
            next_st.gap_cnt = '0;
            next_st.gap_seen = 1'b1;
        end else if (st.gap_cnt != '1) begin
            next_st.gap_cnt = st.gap_cnt + 1'b1;
        end
    end

    // state register; pin idles high from reset
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
            st.pin <= PIN_IDLE;
            st.rd_state <= RD_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign ready_serial_out_pin_o = st.pin;
    assign result_o = st.result;
    assign conv_done_o = st.done;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    localparam int MIN_GAP = TICK_DIV * CONV_SAMPLES - 1;

    sequence s_result_loaded;
        last_pop ##1 (st.rd_state == RD_READY);
    endsequence

    sequence s_shift_started;
        (st.rd_state == RD_READY) && sclk_rise && !pop;
    endsequence

    // result arrival drops the pin and restarts the filter
    AST_READY_LOW: assert property (s_result_loaded |-> !st.pin)
        else $error("pin not low after new result");

    AST_FALL_AT_START: assert property (
        last_pop |=> !st.pin && st.acc == '0 && st.samp_cnt == '0
                 && st.done)
        else $error("pin fall not aligned to conversion start");

    AST_MSB_FIRST: assert property (
        s_shift_started |=> st.pin == $past(st.shreg[RES_W-1])
                     && st.rd_state == RD_SHIFT && st.bit_cnt == BIT_W'(1))
        else $error("first rise did not present MSB");

    AST_NEXT_BIT: assert property (
        (st.rd_state == RD_SHIFT) && sclk_rise && !pop
        && (st.bit_cnt != BIT_LAST)
        |=> st.pin == $past(st.shreg[RES_W-1])
            && st.bit_cnt == $past(st.bit_cnt) + 1'b1)
        else $error("rise did not shift next lower bit");

    AST_FALL_NO_SHIFT: assert property (
        sclk_fall && !pop |=> $stable(st.pin) && $stable(st.bit_cnt))
        else $error("falling edge changed the pin");

    AST_FORCE_HIGH: assert property (
        (st.rd_state == RD_SHIFT) && sclk_rise && !pop
        && (st.bit_cnt == BIT_LAST)
        |=> st.pin && st.rd_state == RD_IDLE)
        else $error("extra rise did not force pin high");

    AST_IDLE_HIGH: assert property (
        (st.rd_state == RD_IDLE) && !last_pop |=> st.pin)
        else $error("pin fell without a new result");

    AST_CLIP: assert property (
        pop && $signed(fifo_data) > $signed({2'b00, FS_POS})
        |-> samp_clip == FS_POS)
        else $error("sample above full scale not clipped");

    AST_RATE: assert property (
        last_pop && st.gap_seen |-> st.gap_cnt >= GAP_W'(MIN_GAP))
        else $error("results closer than one conversion period");

    AST_ONE_SHIFT: assert property (
        sclk_rise |=> !sclk_rise)
        else $error("one shift-clock edge seen twice");

endmodule

// >>> verif/adcrd_host_model.sv
`timescale 1ns/1ps
// host side: drives the shift clock, reads the combined pin
module adcrd_host_model (
    input  wire logic pin_i,
    output logic      shift_clk_o
);
    // shift clock stands low between frames
    initial shift_clk_o = 1'b0;

    // 24 rises give the bits msb first, rise 25 parks the pin high
    task automatic read_word(output logic [23:0] word,
                             output logic        after);
        for (int i = 0; i < 25; i++) begin
            shift_clk_o = 1'b1;
            #80;
            shift_clk_o = 1'b0;
            #70;
            if (i < 24) word[23-i] = pin_i;
            else after = pin_i;
            #10;
        end
    endtask
endmodule

// >>> verif/adc_two_wire_result_readout_bench.sv
`timescale 1ns/1ps
module adc_two_wire_result_readout_bench;
    import adcrd_pkg::*;

    logic              ref_clk_i = 1'b0;
    logic              reset_i   = 1'b1;
    logic [SAMP_W-1:0] samp_data_i  = '0;
    logic              samp_valid_i = 1'b0;
    logic              samp_ready_o;
    logic              shift_clk_i;
    logic              ready_serial_out_pin_o;
    logic [RES_W-1:0]  result_o;
    logic              conv_done_o;
    int                failures = 0;
    int                n_tests  = 0;
    logic [23:0]       word;
    logic              after;
    int                rise_at;
    int                done_at;

    // short modulator tick keeps each conversion near 20k clocks
    localparam int BENCH_TICK = 16;
    localparam int WAIT_MAX   = 2 * BENCH_TICK * CONV_SAMPLES;

    // 50 MHz system clock, never stopped
    always #10 ref_clk_i = ~ref_clk_i;

    adcrd_readout #(
        .TICK_DIV (BENCH_TICK)
    ) dut_u (
        .ref_clk_i              (ref_clk_i),
        .reset_i                (reset_i),
        .samp_data_i            (samp_data_i),
        .samp_valid_i           (samp_valid_i),
        .samp_ready_o           (samp_ready_o),
        .shift_clk_i            (shift_clk_i),
        .ready_serial_out_pin_o (ready_serial_out_pin_o),
        .result_o               (result_o),
        .conv_done_o            (conv_done_o)
    );

    adcrd_host_model host_u (
        .pin_i       (ready_serial_out_pin_o),
        .shift_clk_o (shift_clk_i)
    );

    // closing report
    task automatic stop_test();
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_word({23'h00_0000, got}, {23'h00_0000, exp});
    endtask

    // filter mean of a constant input, from the package's reciprocal
    function automatic longint mean_of(input longint x);
        return (x * CONV_SAMPLES * longint'(RECIP)) >>> SCALE_SHIFT;
    endfunction

    // filter mean of a constant input, allowing one or two codes of slack
    task automatic check_near(input logic [23:0] got, input longint x);
        longint exp;
        longint diff;
        exp = mean_of(x);
        diff = longint'(signed'(got)) - exp;
        n_tests++;
        if ($isunknown(got) || diff > 2 || diff < -2) begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp[23:0]);
        end
    endtask

    // bounded wait for the result strobe, notes when the pin went high
    task automatic wait_done(input bit hold_hi);
        rise_at = -1;
        done_at = -1;
        for (int i = 0; i < WAIT_MAX && done_at < 0; i++) begin
            @(posedge ref_clk_i);
            #1;
            if (conv_done_o === 1'b1) begin
                done_at = i;
            end else if (ready_serial_out_pin_o === 1'b1) begin
                if (rise_at < 0) rise_at = i;
            end else if (hold_hi) begin
                check_bit(ready_serial_out_pin_o, 1'b1);
            end
        end
        if (done_at < 0) begin
            failures++;
            stop_test();
        end
        check_bit(ready_serial_out_pin_o, 1'b0);
    endtask

    // reset, idle pin, fifo fills until it refuses
    task automatic scen_reset_fill();
        int i;
        repeat (8) @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        check_bit(ready_serial_out_pin_o, 1'b1);
        check_word(result_o, 24'h00_0000);
        samp_data_i  = 26'h100_0000;
        samp_valid_i = 1'b1;
        for (i = 0; i < 64 && samp_ready_o !== 1'b0; i++) begin
            @(posedge ref_clk_i);
            #1;
        end
        check_bit(samp_ready_o, 1'b0);
    endtask

    // over-range input clips, then a full read of the result
    task automatic scen_clip_read();
        wait_done(1'b0);
        check_near(result_o, 64'sd8388607);
        samp_data_i = 26'h3F0_0000;
        host_u.read_word(word, after);
        check_word(word, 24'(mean_of(64'sd8388607)));
        check_bit(after, 1'b1);
        wait_done(1'b1);
    endtask

    // unread result is replaced, update window, settled new input
    task automatic scen_overwrite_settle();
        wait_done(1'b0);
        check_word(24'(done_at - rise_at), 24'(BENCH_TICK));
        check_near(result_o, -64'sd1048576);
        host_u.read_word(word, after);
        check_word(word, 24'(mean_of(-64'sd1048576)));
        check_bit(after, 1'b1);
    endtask

    initial begin
        scen_reset_fill();
        scen_clip_read();
        scen_overwrite_settle();
        stop_test();
    end
endmodule
